// file: hw/sdf_data_ack.sv
/*
 * data filter and data-acknowledge event path of a sigma-delta filter.
 * the link side runs on the modulator clock; flags live on clk_sys.
 * assumes: filter_reset_pulse, filter_en, flag_clear and enables come from
 * logic on clk_sys; mod_bit changes with the modulator clock.
 */
// Summary of operation
// - on the first configure and enable the filter may give one early acknowledge before it settles.
// - after that early one every acknowledge and dma request follows the window set by the filter.
// - a filter reset pulse while the filter is on resynchronises it and may give one early acknowledge; pulses while off are refused.
// - after a filter reset pulse acknowledges follow the window until the next pulse.
module sdf_data_ack
    import sdf_pkg::*;
(
    input  wire logic                  clk_sys,            // system clock
    input  wire logic                  rst,                // sync reset, high
    input  wire logic                  mod_clk,            // modulator_clock
    input  wire logic                  mod_bit,            // modulator bitstream
    input  wire logic                  filter_en,          // data filter enable
    input  wire logic                  filter_reset_pulse, // pwm resync pulse
    input  wire logic                  ack_int_en,         // ack interrupt enable
    input  wire logic                  dma_en,             // dma request enable
    input  wire logic                  flag_clear,         // clear ack flag pulse
    output logic [SDF_DATA_W-1:0]      filter_data,        // last filter sample
    output logic                       data_ack_event,     // one-cycle ack pulse
    output logic                       ack_flag,           // sticky ack flag
    output logic                       ack_irq,            // flag gated by enable
    output logic                       dma_req             // one-cycle dma pulse
);

    // system side: resync toggle for the link domain
    // a one-cycle pulse could fall between modulator edges, a toggle cannot
    logic frs_tog_q;
    logic frs_tog_d;

    always_comb begin
        frs_tog_d = frs_tog_q ^ filter_reset_pulse;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            frs_tog_q <= 1'b0;
        end else begin
            frs_tog_q <= frs_tog_d;
        end
    end

    // link side crossings in
    logic [2:0] lk_in;
    logic       rst_l;
    logic       en_l;
    logic       frs_l;

    // reset rides the same two flops, so it lands together with the enable
    sdf_sync #(.W(3)) u_sync_link (
        .clk  (mod_clk),
        .din  ({rst, filter_en, frs_tog_q}),
        .dout (lk_in)
    );

    always_comb begin
        rst_l = lk_in[2];
        en_l  = lk_in[1];
        frs_l = lk_in[0];
    end

    // link side filter
    sdf_state_t            st_q;
    sdf_state_t            st_d;
    logic [SDF_CNT_W-1:0]  cnt_q;
    logic [SDF_CNT_W-1:0]  cnt_d;
    logic [SDF_DATA_W-1:0] acc_q;
    logic [SDF_DATA_W-1:0] acc_d;
    logic [SDF_DATA_W-1:0] smp_q;
    logic [SDF_DATA_W-1:0] smp_d;
    logic                  ev_tog_q;
    logic                  ev_tog_d;
    logic                  frs_prev_q;
    logic                  frs_prev_d;
    logic                  bit_q;
    logic                  bit_d;
    logic                  frs_seen;
    logic                  bound;

    // window end decode, shared by the short first window and the full one
    function automatic logic window_end(input logic [SDF_CNT_W-1:0] cnt,
                                        input logic [SDF_CNT_W-1:0] last);
        return cnt == last;
    endfunction

    always_comb begin
        st_d     = st_q;
        cnt_d    = cnt_q + 5'h01;
        acc_d    = acc_q + {5'h00, bit_q};
        smp_d    = smp_q;
        ev_tog_d = ev_tog_q;
        frs_seen = frs_l ^ frs_prev_q;
        bound    = 1'b0;
        bit_d      = mod_bit;
        frs_prev_d = frs_l;
        case (st_q)
            SDF_OFF: begin
                cnt_d = SDF_CNT_RST;
                acc_d = SDF_ACC_RST;
                if (en_l) begin
                    st_d = SDF_FILL;
                end
            end
            SDF_FILL: begin
                // window not yet full: the early ack carries a partial sum
                bound = window_end(cnt_q, SDF_CNT_EARLY);
                if (bound) begin
                    st_d = SDF_RUN;
                end
            end
            SDF_RUN: begin
                // full window of SDF_OSR modulator clocks
                bound = window_end(cnt_q, SDF_CNT_LAST);
            end
            default: begin
                st_d = SDF_OFF;
            end
        endcase
        if (bound) begin
            smp_d    = acc_d;
            acc_d    = SDF_ACC_RST;
            cnt_d    = SDF_CNT_RST;
            ev_tog_d = ~ev_tog_q;
        end
        // pulses while off only move the history, so they are refused
        if (st_q != SDF_OFF && frs_seen) begin
            // resync restarts the window, so the next ack comes early again
            st_d  = SDF_FILL;
            cnt_d = SDF_CNT_RST;
            acc_d = SDF_ACC_RST;
        end
        if (!en_l) begin
            st_d = SDF_OFF;
        end
    end

    always_ff @(posedge mod_clk) begin
        // bitstream and edge history run through reset
        bit_q      <= bit_d;
        frs_prev_q <= frs_prev_d;
        if (rst_l) begin
            st_q     <= SDF_OFF;
            cnt_q    <= SDF_CNT_RST;
            acc_q    <= SDF_ACC_RST;
            smp_q    <= SDF_ACC_RST;
            ev_tog_q <= 1'b0;
        end else begin
            st_q     <= st_d;
            cnt_q    <= cnt_d;
            acc_q    <= acc_d;
            smp_q    <= smp_d;
            ev_tog_q <= ev_tog_d;
        end
    end

    // system side: event toggle back; smp_q is stable for a window after it
    logic       ev_s;
    logic       ev_prev_q;
    logic       ev_seen;

    sdf_sync #(.W(1)) u_sync_sys (
        .clk  (clk_sys),
        .din  (ev_tog_q),
        .dout (ev_s)
    );

    logic [SDF_DATA_W-1:0] data_q;
    logic [SDF_DATA_W-1:0] data_d;
    logic                  ack_q;
    logic                  ack_d;
    logic                  flag_q;
    logic                  flag_d;
    logic                  irq_q;
    logic                  irq_d;
    logic                  dma_q;
    logic                  dma_d;

    always_comb begin
        ev_seen = ev_s ^ ev_prev_q;
        // word taken only on the event edge, never while it moves
        data_d  = ev_seen ? smp_q : data_q;
        ack_d   = ev_seen;
        dma_d   = ev_seen & dma_en;
        // set wins over a clear in the same cycle
        flag_d  = ev_seen | (flag_q & ~flag_clear);
        // irq uses the next flag value, so it rises with the flag
        irq_d   = flag_d & ack_int_en;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ev_prev_q <= 1'b0;
            data_q    <= SDF_ACC_RST;
            ack_q     <= 1'b0;
            flag_q    <= 1'b0;
            irq_q     <= 1'b0;
            dma_q     <= 1'b0;
        end else begin
            ev_prev_q <= ev_s;
            data_q    <= data_d;
            ack_q     <= ack_d;
            flag_q    <= flag_d;
            irq_q     <= irq_d;
            dma_q     <= dma_d;
        end
    end

    // outputs straight from the system-side flops
    assign filter_data    = data_q;
    assign data_ack_event = ack_q;
    assign ack_flag       = flag_q;
    assign ack_irq        = irq_q;
    assign dma_req        = dma_q;

endmodule

// file: hw/sdf_pkg.sv
/*
 * constants and types shared by the data-acknowledge block.
 * assumes: one system clock at 50 MHz and a free modulator clock.
 */
package sdf_pkg;

    // decimation window in modulator clocks
    localparam int unsigned SDF_OSR           = 32;
    localparam int unsigned SDF_CNT_W         = 5;
    localparam int unsigned SDF_DATA_W        = 6;
    localparam int unsigned SDF_SYNC_STAGES   = 2;

    // last count of a full window and of the shortened first window
    localparam logic [SDF_CNT_W-1:0]  SDF_CNT_LAST  = 5'h1f;
    localparam logic [SDF_CNT_W-1:0]  SDF_CNT_EARLY = 5'h0f;
    localparam logic [SDF_CNT_W-1:0]  SDF_CNT_RST   = 5'h00;
    localparam logic [SDF_DATA_W-1:0] SDF_ACC_RST   = 6'h00;

    // host settle figure, kept here for the bench
    localparam int unsigned SDF_SETTLE_MCLK   = 5;
    localparam real         SDF_AUX_DELAY_US  = 1.2;
    localparam real         SDF_CLK_MHZ       = 50.0;
    localparam int unsigned SDF_AUX_DELAY_CYC = $rtoi(SDF_AUX_DELAY_US * SDF_CLK_MHZ + 0.999);

    // filter state, gray along off -> fill -> run
    typedef enum logic [1:0] {
        SDF_OFF  = 2'b00,
        SDF_FILL = 2'b01,
        SDF_RUN  = 2'b11
    } sdf_state_t;

endpackage

// file: hw/sdf_sync.sv
/*
 * multi-bit level synchroniser, two flops per bit.
 * assumes: each bit is an independent level or toggle.
 */
module sdf_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk,   // destination clock
    input  wire logic [W-1:0] din,   // foreign-domain levels
    output logic      [W-1:0] dout   // synchronised levels
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_d;

    always_comb begin
        meta_d = din;
        sync_d = meta_q;
    end

    // first stage feeds only the second
    always_ff @(posedge clk) begin
        meta_q <= meta_d;
        dout   <= sync_d;
    end

endmodule

// file: test/sdf_data_ack_tb.sv
/* bench: enable, resync and disable of the ack path.
   assumes: package, design and modulator model compiled before. */
module sdf_data_ack_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import sdf_pkg::*;
    logic clk_sys, rst, filter_en, filter_reset_pulse, ack_int_en, dma_en, flag_clear, level;
    logic mod_clk, mod_bit, data_ack_event, ack_flag, ack_irq, dma_req;
    logic [SDF_DATA_W-1:0] filter_data;
    int   n_mismatch, samples_checked, gap, cyc, ev_cyc;
    // cycle stamp moves on the rising edge, read at the falling one
    always @(posedge clk_sys) cyc <= cyc + 1;
    sdf_mod_model sdf_mod_model_inst (.level, .mod_clk, .mod_bit);
    sdf_data_ack sdf_data_ack_inst (.clk_sys, .rst, .mod_clk, .mod_bit, .filter_en,
        .filter_reset_pulse, .ack_int_en, .dma_en, .flag_clear, .filter_data,
        .data_ack_event, .ack_flag, .ack_irq, .dma_req);
    // pure windows only: mixed ones are never checked
    function automatic logic [31:0] model();
        return level ? SDF_OSR : 0;
    endfunction
    task automatic check(logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // gap: system cycles since the previous event seen
    task automatic wait_ev();
        int n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (data_ack_event !== 1'b1 && n < 400);
        if (n >= 400) n_mismatch++;
        gap = cyc - ev_cyc;
        ev_cyc = cyc;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk_sys);
        s = 1'b0;
    endtask
    task automatic finish_test();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        #100us;
        n_mismatch++;
        finish_test();
    end
    initial begin
        {rst, filter_en, filter_reset_pulse, ack_int_en, dma_en, flag_clear, level} = 7'h40;
        void'($urandom(32'hb356bcb7));
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        level = 1'($urandom);
        filter_en = 1'b1;
        wait_ev(); // early ack, data not yet valid
        wait_ev();
        check(32'(filter_data), model());
        repeat (SDF_SETTLE_MCLK) @(posedge mod_clk); // settled, plus 5 modulator clocks
        @(negedge clk_sys);
        ack_int_en = 1'b1;
        dma_en = 1'b1;
        wait_ev();
        check(32'(gap inside {[49:54]}), 1);
        check(32'(dma_req), 1);
        @(negedge clk_sys);
        check(32'(ack_irq), 1);
        pulse(flag_clear);
        check(32'(ack_flag), 0);
        $display("test enable done");
        level = ~level;
        repeat ($urandom_range(20, 1)) @(negedge clk_sys);
        pulse(filter_reset_pulse);
        repeat (SDF_AUX_DELAY_CYC) @(negedge clk_sys); // aux interrupt delay
        check(32'(ack_flag), 1);
        pulse(flag_clear);
        check(32'(ack_flag), 0);
        for (int k = 1; k <= 3; k++) begin
            wait_ev();
            check(32'(filter_data), model());
            if (k > 1) check(32'(gap inside {[49:54]}), 1);
            if (k <= 2) pulse(flag_clear); // clear up to N of 2 only
        end
        repeat (60) @(negedge clk_sys);
        check(32'(ack_flag), 1);
        $display("test resync done");
        filter_en = 1'b0;
        repeat (20) @(negedge clk_sys);
        pulse(filter_reset_pulse);
        gap = 0;
        repeat (300) begin
            @(negedge clk_sys);
            gap += int'(data_ack_event === 1'b1);
        end
        check(32'(gap), 0);
        $display("test disable done");
        finish_test();
    end
endmodule
bind sdf_data_ack sdf_sva sdf_sva_inst (.clk_sys, .rst, .ack_int_en, .flag_clear, .dma_en,
    .data_ack_event, .ack_flag, .ack_irq, .dma_req);

// file: test/sdf_mod_model.sv
/* modulator model: free clock and a level bitstream.
   assumes: the bench picks the level; the clock never stops. */
module sdf_mod_model (
    input  wire logic level,   // bit value to send
    output logic      mod_clk, // modulator_clock
    output logic      mod_bit  // bitstream
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        mod_clk = 1'b0;
        mod_bit = 1'b0;
        #7;
        forever #16 mod_clk = ~mod_clk;
    end
    // change away from the sampling edge
    always @(negedge mod_clk) mod_bit <= level;
endmodule

// file: test/sdf_sva.sv
/* checker of the ack flag, irq and dma outputs.
   assumes: bound to sdf_data_ack, one clock domain. */
module sdf_sva (
    input wire logic clk_sys,        // system clock
    input wire logic rst,            // sync reset
    input wire logic ack_int_en,     // irq enable
    input wire logic flag_clear,     // clear pulse
    input wire logic dma_en,         // dma enable
    input wire logic data_ack_event, // ack pulse
    input wire logic ack_flag,       // sticky flag
    input wire logic ack_irq,        // gated flag
    input wire logic dma_req         // dma pulse
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_ev_sets_flag: assert property (data_ack_event |-> ack_flag)
        else $error("flag not set");
    a_flag_holds: assert property (ack_flag && !flag_clear |=> ack_flag)
        else $error("flag lost");
    a_clear_drops: assert property (flag_clear |=> !ack_flag || data_ack_event)
        else $error("flag not cleared");
    a_irq_on: assert property (data_ack_event && ack_int_en && !flag_clear |=> ack_irq)
        else $error("irq missing");
    a_dma_on_ev: assert property (dma_req |-> data_ack_event)
        else $error("stray dma");
    a_ev_spaced: assert property (data_ack_event |=> !data_ack_event [*8])
        else $error("events too close");
    a_irq_needs_flag: assert property (ack_irq |-> ack_flag)
        else $error("irq without flag");
    a_irq_gated: assert property (!ack_int_en |=> !ack_irq)
        else $error("irq while disabled");
    a_dma_gated: assert property (!dma_en |=> !dma_req)
        else $error("dma while disabled");
endmodule
